// ### src/branch_decode_pkg.sv
// Purpose: Types for the branch, prefix and protection decoder
// Assumes: Nothing
// Notes: Operation classes reported with each decoded instruction
package branch_decode_pkg;
    typedef enum logic [4:0] {
        OPC_NONE, OPC_JCC, OPC_JUMP_COUNT16_ZERO, OPC_JUMP_COUNT32_ZERO, OPC_LOOP,
        OPC_SET_BYTE, OPC_RETURN_NEAR, OPC_RETURN_FAR, OPC_COPROC,
        OPC_LOAD_GLOBAL_TABLE_REG, OPC_LOAD_INTERRUPT_TABLE_REG,
        OPC_STORE_GLOBAL_TABLE_REG, OPC_STORE_INTERRUPT_TABLE_REG,
        OPC_LOAD_MACHINE_STATUS, OPC_STORE_MACHINE_STATUS,
        OPC_ADJUST_REQUESTED_PRIVILEGE, OPC_LOAD_ACCESS_RIGHTS,
        OPC_LOAD_LOCAL_TABLE_REG, OPC_STORE_LOCAL_TABLE_REG,
        OPC_VERIFY_READABLE, OPC_VERIFY_WRITABLE, OPC_INVALID
    } op_class_t;
    typedef enum {ST_FIRST, ST_ESCAPE, ST_MODRM, ST_SKIP} dec_state_t;
endpackage

// ### src/branch_decode_regs.svh
// Purpose: Constants for the branch, prefix and protection decoder
// Assumes: Included by bare name
// Notes: Opcodes, a mod-field code and cycle counts
`ifndef BRANCH_DECODE_REGS_SVH
`define BRANCH_DECODE_REGS_SVH
`define OP_JCC_SHORT_HI 4'h7
`define OP_ESCAPE 8'h0f
`define OP_JCC_FULL_HI 4'h8
`define OP_SETCC_HI 4'h9
`define OP_JUMP_COUNT_ZERO 8'he3
`define OP_LOOP 8'he2
`define OP_RET_NEAR 8'hc3
`define OP_RET_NEAR_IMM 8'hc2
`define OP_RET_FAR 8'hcb
`define OP_RET_FAR_IMM 8'hca
`define OP_COPROC_HI 5'h1b
`define OP_ADJ_PRIV 8'h63
`define OP_GRP_TABLE 8'h01
`define OP_GRP_LOCAL 8'h00
`define OP_ACCESS_RIGHTS 8'h02
`define PFX_ADDR 8'h67
`define PFX_OPER 8'h66
`define PFX_LOCK 8'hf0
`define PFX_SEG_CS 8'h2e
`define PFX_SEG_DS 8'h3e
`define PFX_SEG_ES 8'h26
`define PFX_SEG_FS 8'h64
`define PFX_SEG_GS 8'h65
`define PFX_SEG_SS 8'h36
`define MOD_REGISTER 2'h3
`define CYC_JCC_TAKEN 8'h07
`define CYC_JCC_NOT 8'h03
`define CYC_JCZ_TAKEN 8'h09
`define CYC_JCZ_NOT 8'h05
`define CYC_LOOP 8'h0b
`define CYC_SET_REG 8'h04
`define CYC_SET_MEM 8'h05
`define CYC_RET_NEAR 8'h0a
`define CYC_RET_FAR_REAL 8'h12
`define CYC_RET_FAR_PROT 8'h20
`define CYC_RET_FAR_PRIV 8'h44
`define CYC_LOAD_TABLE 8'h0b
`define CYC_STORE_TABLE 8'h09
`define CYC_LOAD_MACHINE_STATUS_REG 8'h0a
`define CYC_LOAD_MACHINE_STATUS_MEM 8'h0d
`define CYC_STORE_MACHINE_STATUS 8'h02
`define CYC_ADJUST_REQUESTED_PRIVILEGE_REG 8'h14
`define CYC_ADJUST_REQUESTED_PRIVILEGE_MEM 8'h15
`define CYC_LAR_REG 8'h0f
`define CYC_LAR_MEM 8'h10
`define CYC_LOAD_LOCAL_TABLE_REG_REG 8'h14
`define CYC_LOAD_LOCAL_TABLE_REG_MEM 8'h18
`define CYC_STORE_LOCAL_TABLE_REG 8'h02
`define CYC_VERIFY_READABLE_REG 8'h0a
`define CYC_VERIFY_READABLE_MEM 8'h0b
`define CYC_VERIFY_WRITABLE_REG 8'h0f
`define CYC_VERIFY_WRITABLE_MEM 8'h10
`define EXC_INVALID_OP 5'h06
`define EXC_GEN_PROT 5'h0d
`endif

// ### src/branch_prefix_protection_decode.sv
// Contract
// [RL1] Decode short and full conditional jumps
// [RL2] Condition field selects sixteen flag tests
// [RL3] Jcc costs 7 plus m, else 3
// [RL4] Count-zero jump, size by address prefix
// [RL5] Loop decrements count, 11 plus m
// [RL6] Set byte on condition, 4/5 cycles
// [RL7] Near returns cost 10 plus m
// [RL8] Far return 18 or 32 plus m
// [RL9] Privilege-changing far return takes 68
// [RL10] Prefixes consumed at zero cycles
// [RL11] Escape 11011 passes bits to coprocessor
// [RL12] Table register loads 11, stores 9
// [RL13] Status word load 10/13, store 2
// [RL14] Adjust privilege 20/21, protected only
// [RL15] Access rights 15/16, locked, protected only
// [RL16] Local table load 20/24, store 2
// [RL17] Verify read 10/11, write 15/16
// [RL18] Denied port I/O in compat raises 13
// [RL19] Protected-only op in real mode raises 6
// [RL20] Verify privilege fault clears zero flag
// [RL21] Out-of-limit branch target raises 13
// [RL22] m counts next instruction components
// [RL23] Unassigned group reg field is invalid
// Purpose: Byte-serial decoder giving class, cycles and legality
// Assumes: One byte per valid cycle; execution core reports outcomes
// Notes: Cycle count includes m where the cost has one; m is added from next_components
`timescale 1ns/1ps
`default_nettype none
`include "branch_decode_regs.svh"
module branch_prefix_protection_decode
    import branch_decode_pkg::*;
#(
    parameter int CYC_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fetch byte stream
    input wire logic byte_valid,
    input wire logic [7:0] fetch_byte,
    // Mode and execution outcomes
    input wire logic protected_mode,
    input wire logic compat_mode,
    input wire logic [3:0] flags_osczp,
    input wire logic count_is_zero,
    input wire logic count_after_dec_nonzero,
    input wire logic privilege_change,
    input wire logic io_access,
    input wire logic io_permitted,
    input wire logic target_out_of_limit,
    input wire logic selector_priv_fault,
    input wire logic [3:0] next_components,
    // Decode result
    output logic done,
    output op_class_t op_class,
    output logic [3:0] cond_code,
    output logic cond_true,
    output logic addr32,
    output logic [CYC_W-1:0] cycles,
    output logic locked_access,
    output logic [5:0] coproc_bits,
    output logic [3:0] prefix_count,
    output logic exc_valid,
    output logic [4:0] exc_vector,
    output logic zero_flag_clear
);
    // Cycle counts peak at 68, the privilege return, which takes no m; CYC_W is kept at eight bits or more
    if (CYC_W < 8) $error("CYC_W must be at least 8");

    // Sixteen condition tests; flags_osczp is {of,sf,cf,zf}, parity folded below
    function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f, input logic pf);
        logic r;
        r = 1'b0;
        // [RL2] condition table
        case (c[3:1])
            3'h0: r = f[3];
            3'h1: r = f[1];
            3'h2: r = f[0];
            3'h3: r = f[1] | f[0];
            3'h4: r = f[2];
            3'h5: r = pf;
            3'h6: r = f[2] ^ f[3];
            3'h7: r = (f[2] ^ f[3]) | f[0];
            default: r = 1'b0;
        endcase
        return r ^ c[0];
    endfunction

    // Register-vs-memory cost choice used by many rows
    function automatic logic [7:0] rm_cost(input logic [1:0] md, input logic [7:0] rc, input logic [7:0] mc);
        return (md == `MOD_REGISTER) ? rc : mc;
    endfunction

    // Protection group rows indexed {local group, reg field}; unused rows decode invalid
    localparam op_class_t GRP_CLASS [16] = '{
        OPC_STORE_GLOBAL_TABLE_REG, OPC_STORE_INTERRUPT_TABLE_REG, OPC_LOAD_GLOBAL_TABLE_REG,
        OPC_LOAD_INTERRUPT_TABLE_REG, OPC_STORE_MACHINE_STATUS, OPC_INVALID, OPC_LOAD_MACHINE_STATUS, OPC_INVALID,
        OPC_STORE_LOCAL_TABLE_REG, OPC_INVALID, OPC_LOAD_LOCAL_TABLE_REG, OPC_INVALID,
        OPC_VERIFY_READABLE, OPC_VERIFY_WRITABLE, OPC_INVALID, OPC_INVALID};
    localparam logic [7:0] GRP_REG [16] = '{`CYC_STORE_TABLE, `CYC_STORE_TABLE, `CYC_LOAD_TABLE,
        `CYC_LOAD_TABLE, `CYC_STORE_MACHINE_STATUS, 8'h00, `CYC_LOAD_MACHINE_STATUS_REG, 8'h00, `CYC_STORE_LOCAL_TABLE_REG, 8'h00, `CYC_LOAD_LOCAL_TABLE_REG_REG, 8'h00,
        `CYC_VERIFY_READABLE_REG, `CYC_VERIFY_WRITABLE_REG, 8'h00, 8'h00};
    localparam logic [7:0] GRP_MEM [16] = '{`CYC_STORE_TABLE, `CYC_STORE_TABLE, `CYC_LOAD_TABLE,
        `CYC_LOAD_TABLE, `CYC_STORE_MACHINE_STATUS, 8'h00, `CYC_LOAD_MACHINE_STATUS_MEM, 8'h00, `CYC_STORE_LOCAL_TABLE_REG, 8'h00, `CYC_LOAD_LOCAL_TABLE_REG_MEM, 8'h00,
        `CYC_VERIFY_READABLE_MEM, `CYC_VERIFY_WRITABLE_MEM, 8'h00, 8'h00};

    dec_state_t state_reg, state_next;
    logic [7:0] op_reg, op_next;
    logic addr32_reg, addr32_next;
    logic [3:0] pfx_reg, pfx_next;
    logic lock_pfx_reg, lock_pfx_next;
    logic [2:0] skip_reg, skip_next;
    logic done_reg, done_next;
    op_class_t class_reg, class_next;
    logic [3:0] cc_reg, cc_next;
    logic ct_reg, ct_next;
    logic a32o_reg, a32o_next;
    logic [CYC_W-1:0] cyc_reg, cyc_next;
    logic lk_reg, lk_next;
    logic [5:0] cp_reg, cp_next;
    logic [3:0] pco_reg, pco_next;
    logic exc_reg, exc_next;
    logic [4:0] vec_reg, vec_next;
    logic zfc_reg, zfc_next;
    // Parity is not an input, so parity conditions see it low
    localparam logic pf = 1'b0;

    // Decode sequencing and result computation
    always_comb begin
        logic [2:0] rf;
        logic [CYC_W-1:0] m;
        logic prot_only;
        logic [3:0] gi;
        rf = fetch_byte[5:3];
        gi = {~op_reg[0], rf};
        // [RL22] m from next instruction
        m = CYC_W'(next_components);
        prot_only = 1'b0;
        state_next = state_reg;
        op_next = op_reg;
        addr32_next = addr32_reg;
        pfx_next = pfx_reg;
        lock_pfx_next = lock_pfx_reg;
        skip_next = skip_reg;
        done_next = 1'b0;
        class_next = class_reg;
        cc_next = cc_reg;
        ct_next = ct_reg;
        a32o_next = a32o_reg;
        cyc_next = cyc_reg;
        lk_next = 1'b0;
        cp_next = cp_reg;
        pco_next = pco_reg;
        exc_next = 1'b0;
        vec_next = vec_reg;
        zfc_next = 1'b0;
        if (byte_valid) begin
            case (state_reg)
                ST_FIRST: begin
                    op_next = fetch_byte;
                    // [RL10] prefix consume
                    if (fetch_byte == `PFX_ADDR) begin
                        addr32_next = ~addr32_reg;
                        pfx_next = pfx_reg + 4'h1;
                    end else if (fetch_byte inside {`PFX_OPER, `PFX_SEG_CS, `PFX_SEG_DS, `PFX_SEG_ES,
                                 `PFX_SEG_FS, `PFX_SEG_GS, `PFX_SEG_SS}) begin
                        pfx_next = pfx_reg + 4'h1;
                    end else if (fetch_byte == `PFX_LOCK) begin
                        lock_pfx_next = 1'b1;
                        pfx_next = pfx_reg + 4'h1;
                    end else if (fetch_byte == `OP_ESCAPE) begin
                        state_next = ST_ESCAPE;
                    end else if (fetch_byte[7:3] == `OP_COPROC_HI || fetch_byte == `OP_ADJ_PRIV) begin
                        // [RL11] coprocessor escape takes modrm
                        state_next = ST_MODRM;
                    end else begin
                        done_next = 1'b1;
                        cc_next = fetch_byte[3:0];
                        class_next = OPC_INVALID;
                        cyc_next = '0;
                        if (fetch_byte[7:4] == `OP_JCC_SHORT_HI) begin
                            // [RL1] short form, [RL3] taken or not
                            class_next = OPC_JCC;
                            ct_next = cond_eval(fetch_byte[3:0], flags_osczp, pf);
                            cyc_next = ct_next ? CYC_W'(`CYC_JCC_TAKEN) + m : CYC_W'(`CYC_JCC_NOT);
                            skip_next = 3'h1;
                        end else if (fetch_byte == `OP_JUMP_COUNT_ZERO) begin
                            // [RL4] count zero jump
                            class_next = addr32_reg ? OPC_JUMP_COUNT32_ZERO : OPC_JUMP_COUNT16_ZERO;
                            ct_next = count_is_zero;
                            cyc_next = count_is_zero ? CYC_W'(`CYC_JCZ_TAKEN) + m : CYC_W'(`CYC_JCZ_NOT);
                            skip_next = 3'h1;
                        end else if (fetch_byte == `OP_LOOP) begin
                            // [RL5] loop cost
                            class_next = OPC_LOOP;
                            ct_next = count_after_dec_nonzero;
                            cyc_next = CYC_W'(`CYC_LOOP) + m;
                            skip_next = 3'h1;
                        end else if (fetch_byte == `OP_RET_NEAR || fetch_byte == `OP_RET_NEAR_IMM) begin
                            // [RL7] near return
                            class_next = OPC_RETURN_NEAR;
                            cyc_next = CYC_W'(`CYC_RET_NEAR) + m;
                            skip_next = fetch_byte[0] ? 3'h0 : 3'h2;
                        end else if (fetch_byte == `OP_RET_FAR || fetch_byte == `OP_RET_FAR_IMM) begin
                            // [RL8] far return, [RL9] privilege change
                            class_next = OPC_RETURN_FAR;
                            cyc_next = (protected_mode && privilege_change) ? CYC_W'(`CYC_RET_FAR_PRIV) :
                                CYC_W'(protected_mode ? `CYC_RET_FAR_PROT : `CYC_RET_FAR_REAL) + m;
                            skip_next = fetch_byte[0] ? 3'h0 : 3'h2;
                        end
                        // [RL18] denied port access, [RL21] branch target limit
                        exc_next = (compat_mode && io_access && !io_permitted) || (class_next != OPC_INVALID &&
                            target_out_of_limit && (ct_next || class_next inside {OPC_RETURN_NEAR, OPC_RETURN_FAR}));
                        vec_next = `EXC_GEN_PROT;
                        if (skip_next != 3'h0) state_next = ST_SKIP;
                    end
                end
                ST_ESCAPE: begin
                    op_next = fetch_byte;
                    if (fetch_byte[7:4] == `OP_JCC_FULL_HI) begin
                        // [RL1] full form, [RL3] same costs
                        done_next = 1'b1;
                        class_next = OPC_JCC;
                        cc_next = fetch_byte[3:0];
                        ct_next = cond_eval(fetch_byte[3:0], flags_osczp, pf);
                        cyc_next = ct_next ? CYC_W'(`CYC_JCC_TAKEN) + m : CYC_W'(`CYC_JCC_NOT);
                        exc_next = ct_next & target_out_of_limit;
                        vec_next = `EXC_GEN_PROT;
                        skip_next = addr32_reg ? 3'h4 : 3'h2;
                        state_next = ST_SKIP;
                    end else if (fetch_byte[7:4] == `OP_SETCC_HI || fetch_byte == `OP_GRP_TABLE ||
                                 fetch_byte == `OP_GRP_LOCAL || fetch_byte == `OP_ACCESS_RIGHTS) begin
                        state_next = ST_MODRM;
                    end else begin
                        done_next = 1'b1;
                        class_next = OPC_INVALID;
                        exc_next = 1'b1;
                        vec_next = `EXC_INVALID_OP;
                        state_next = ST_FIRST;
                    end
                end
                ST_MODRM: begin
                    done_next = 1'b1;
                    cc_next = op_reg[3:0];
                    ct_next = 1'b0;
                    cp_next = 6'h0;
                    class_next = OPC_INVALID;
                    cyc_next = '0;
                    if (op_reg[7:3] == `OP_COPROC_HI) begin
                        // [RL11] pass opcode bits on
                        class_next = OPC_COPROC;
                        cp_next = {op_reg[2:0], rf};
                    end else if (op_reg == `OP_ADJ_PRIV) begin
                        // [RL14] adjust privilege
                        class_next = OPC_ADJUST_REQUESTED_PRIVILEGE;
                        cyc_next = CYC_W'(rm_cost(fetch_byte[7:6], `CYC_ADJUST_REQUESTED_PRIVILEGE_REG, `CYC_ADJUST_REQUESTED_PRIVILEGE_MEM));
                        prot_only = 1'b1;
                    end else if (op_reg[7:4] == `OP_SETCC_HI) begin
                        // [RL6] set byte
                        class_next = OPC_SET_BYTE;
                        ct_next = cond_eval(op_reg[3:0], flags_osczp, pf);
                        cyc_next = CYC_W'(rm_cost(fetch_byte[7:6], `CYC_SET_REG, `CYC_SET_MEM));
                    end else if (op_reg == `OP_ACCESS_RIGHTS) begin
                        // [RL15] access rights, locked
                        class_next = OPC_LOAD_ACCESS_RIGHTS;
                        cyc_next = CYC_W'(rm_cost(fetch_byte[7:6], `CYC_LAR_REG, `CYC_LAR_MEM));
                        prot_only = 1'b1;
                        lk_next = 1'b1;
                    end else begin
                        // [RL12] [RL13] [RL16] [RL17] [RL23] group rows
                        class_next = GRP_CLASS[gi];
                        cyc_next = CYC_W'(rm_cost(fetch_byte[7:6], GRP_REG[gi], GRP_MEM[gi]));
                        prot_only = (op_reg == `OP_GRP_LOCAL);
                        // Descriptor table accesses lock the bus
                        lk_next = class_next inside {OPC_LOAD_LOCAL_TABLE_REG, OPC_VERIFY_READABLE,
                                                     OPC_VERIFY_WRITABLE};
                    end
                    // [RL20] no fault on verify, zero flag cleared
                    if (class_next == OPC_VERIFY_READABLE || class_next == OPC_VERIFY_WRITABLE ||
                        class_next == OPC_LOAD_ACCESS_RIGHTS)
                        zfc_next = selector_priv_fault;
                    // [RL19] real-mode invalid, [RL23] unassigned reg field
                    if (class_next == OPC_INVALID || (prot_only && !protected_mode)) begin
                        exc_next = 1'b1;
                        vec_next = `EXC_INVALID_OP;
                        zfc_next = 1'b0;
                    end
                    state_next = ST_FIRST;
                end
                ST_SKIP: begin
                    // Displacement and immediate bytes are only counted off
                    skip_next = skip_reg - 3'h1;
                    if (skip_reg == 3'h1) state_next = ST_FIRST;
                end
                default: state_next = ST_FIRST;
            endcase
            // Prefix state is spent once an instruction completes
            if (done_next) begin
                a32o_next = addr32_reg;
                pco_next = pfx_reg;
                lk_next = lk_next | lock_pfx_reg;
                pfx_next = '0;
                addr32_next = 1'b0;
                lock_pfx_next = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_FIRST;
            class_reg <= OPC_NONE;
            {op_reg, addr32_reg, pfx_reg, lock_pfx_reg, skip_reg, done_reg, cc_reg, ct_reg, a32o_reg} <= '0;
            {cyc_reg, lk_reg, cp_reg, pco_reg, exc_reg, vec_reg, zfc_reg} <= '0;
        end else begin
            state_reg <= state_next;
            class_reg <= class_next;
            {op_reg, addr32_reg, pfx_reg, lock_pfx_reg, skip_reg, done_reg, cc_reg, ct_reg, a32o_reg} <=
                {op_next, addr32_next, pfx_next, lock_pfx_next, skip_next, done_next, cc_next, ct_next, a32o_next};
            {cyc_reg, lk_reg, cp_reg, pco_reg, exc_reg, vec_reg, zfc_reg} <=
                {cyc_next, lk_next, cp_next, pco_next, exc_next, vec_next, zfc_next};
        end
    end

    // Outputs straight from flops
    assign done = done_reg;
    assign op_class = class_reg;
    assign cond_code = cc_reg;
    assign cond_true = ct_reg;
    assign addr32 = a32o_reg;
    assign cycles = cyc_reg;
    assign locked_access = lk_reg;
    assign coproc_bits = cp_reg;
    assign prefix_count = pco_reg;
    assign exc_valid = exc_reg;
    assign exc_vector = vec_reg;
    assign zero_flag_clear = zfc_reg;
endmodule
`default_nettype wire

// ### testbench/decode_asserts.sv
// Purpose: Port checks for the branch decoder
// Assumes: Inputs hold from the completing byte until done
// Notes: The m term is sampled one edge before done
`timescale 1ns/1ps
`default_nettype none
module decode_asserts import branch_decode_pkg::*; #(parameter int CYC_W = 8) (
    // Watched ports
    input wire logic clk, reset, protected_mode, privilege_change, done, cond_true, exc_valid, zero_flag_clear,
    input wire logic [3:0] next_components,
    input wire op_class_t op_class,
    input wire logic [CYC_W-1:0] cycles,
    input wire logic [4:0] exc_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_jump_taken_cost: assert property (done && op_class == OPC_JCC && cond_true
        |-> cycles == 7 + $past(next_components)) else $error("taken jump cost");
    chk_jump_not_taken: assert property (done && op_class == OPC_JCC && !cond_true
        |-> cycles == 3) else $error("untaken jump cost");
    chk_loop_cost: assert property (done && op_class == OPC_LOOP
        |-> cycles == 11 + $past(next_components)) else $error("loop cost");
    chk_near_return_cost: assert property (done && op_class == OPC_RETURN_NEAR
        |-> cycles == 10 + $past(next_components)) else $error("near return cost");
    chk_far_return_real: assert property (done && op_class == OPC_RETURN_FAR && !$past(protected_mode)
        |-> cycles == 18 + $past(next_components)) else $error("far return cost");
    chk_far_return_priv: assert property (done && op_class == OPC_RETURN_FAR && $past(protected_mode)
        && $past(privilege_change) |-> cycles == 68) else $error("privilege return cost");
    chk_status_store_cost: assert property (done && op_class == OPC_STORE_MACHINE_STATUS
        |-> cycles == 2) else $error("status store cost");
    chk_real_mode_fault: assert property (done && op_class == OPC_ADJUST_REQUESTED_PRIVILEGE
        && !$past(protected_mode) |-> exc_valid && exc_vector == 6) else $error("real mode fault");
    chk_zero_flag_source: assert property (zero_flag_clear |-> done && op_class inside
        {OPC_VERIFY_READABLE, OPC_VERIFY_WRITABLE, OPC_LOAD_ACCESS_RIGHTS}) else $error("zero flag source");
endmodule
`default_nettype wire

// ### testbench/fetch_model.sv
// Purpose: Fetch queue handing the decoder one byte per cycle, or every other cycle when slow
// Assumes: The bench pushes whole instructions
// Notes: Idle byte line toggles so a stale byte never looks valid
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    // Clock, pacing and fetch stream
    input wire logic clk, slow,
    output logic byte_valid,
    output logic [7:0] fetch_byte
);
    logic [7:0] q[$];
    logic n = 1'b0;
    task push(input logic [7:0] b); q.push_back(b); endtask
    // Slow pacing leaves a gap every other cycle
    always @(negedge clk) begin
        n <= ~n;
        if (q.size() != 0 && !(slow && n)) begin byte_valid <= 1'b1; fetch_byte <= q.pop_front(); end
        else begin byte_valid <= 1'b0; fetch_byte <= ~fetch_byte; end
    end
    initial begin byte_valid = 1'b0; fetch_byte = 8'h00; end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Random and corner decode of branch, prefix and protection ops
// Assumes: Mode and outcome inputs hold for a whole instruction
// Notes: Exceptions are judged by vector alone
`timescale 1ns/1ps
`default_nettype none
module tb;
    import branch_decode_pkg::*;
    logic clk = 0, reset = 1, slow = 0, protected_mode = 0, compat_mode = 0, count_is_zero = 0;
    logic count_after_dec_nonzero = 0, privilege_change = 0, io_access = 0, io_permitted = 1;
    logic target_out_of_limit = 0, selector_priv_fault = 0, byte_valid, done, cond_true, addr32;
    logic locked_access, exc_valid, zero_flag_clear;
    logic [7:0] fetch_byte, cycles, lf = 8'h33;
    logic [3:0] flags_osczp = 0, next_components = 0, cond_code, prefix_count;
    logic [5:0] coproc_bits;
    logic [4:0] exc_vector;
    op_class_t op_class;
    int err_count = 0, samples_checked = 0;
    op_class_t gc[16] = '{OPC_STORE_GLOBAL_TABLE_REG, OPC_STORE_INTERRUPT_TABLE_REG, OPC_LOAD_GLOBAL_TABLE_REG,
        OPC_LOAD_INTERRUPT_TABLE_REG, OPC_STORE_MACHINE_STATUS, OPC_INVALID, OPC_LOAD_MACHINE_STATUS, OPC_INVALID,
        OPC_STORE_LOCAL_TABLE_REG, OPC_INVALID, OPC_LOAD_LOCAL_TABLE_REG, OPC_INVALID, OPC_VERIFY_READABLE,
        OPC_VERIFY_WRITABLE, OPC_INVALID, OPC_INVALID};
    logic [7:0] gy[16] = '{8'h09, 8'h09, 8'h0b, 8'h0b, 8'h02, 8'h00, 8'h0d, 8'h00, 8'h02, 8'h00, 8'h18, 8'h00,
        8'h0b, 8'h10, 8'h00, 8'h00};
    // Clock and parts
    always #2 clk = ~clk;
    fetch_model fq (.clk(clk), .slow(slow), .byte_valid(byte_valid), .fetch_byte(fetch_byte));
    branch_prefix_protection_decode #(.CYC_W(8)) dut (.*);
    function automatic logic [7:0] rnd(); lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]}; return lf; endfunction
    // Flag test per condition field; parity reads as zero
    function automatic logic ct(input logic [3:0] c, input logic [3:0] f);
        logic [7:0] t = {(f[2] ^ f[3]) | f[0], f[2] ^ f[3], 1'b0, f[2], f[1] | f[0], f[0], f[1], f[3]};
        return t[c[3:1]] ^ c[0];
    endfunction
    task rin; {flags_osczp, next_components} = rnd(); {count_is_zero, count_after_dec_nonzero,
        privilege_change, compat_mode, selector_priv_fault, slow} = 6'(rnd()); endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin err_count++; $display("Error %s expected %h seen %h", n, e, s); end
    endtask
    task tally_and_finish;
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One instruction: class and cost, or the fault vector alone
    task op(input logic [7:0] b[$], input op_class_t ec, input logic [7:0] ey, input logic [4:0] ex);
        int k;
        foreach (b[i]) fq.push(b[i]);
        for (k = 0; k < 24 && done !== 1'b1; k++) @(negedge clk);
        if (k == 24) begin err_count++; $display("Error done expected 1 seen 0"); tally_and_finish; end
        chk("exc_valid", ex != 0, exc_valid);
        if (ex != 0) chk("exc_vector", ex, exc_vector);
        else begin chk("op_class", ec, op_class); if (ey != 8'hff) chk("cycles", ey, cycles); end
        repeat (10) @(negedge clk);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        reset = 0;
        for (int c = 0; c < 16; c++) begin
            rin; op('{{4'h7, c[3:0]}, 8'h01}, OPC_JCC, ct(c, flags_osczp) ? 8'h07 + next_components : 8'h03, 0);
            rin; op('{8'h67, 8'h0f, {4'h8, c[3:0]}, 0, 0, 0, 0}, OPC_JCC, ct(c, flags_osczp) ? 8'h07 + next_components : 8'h03, 0);
            rin; op('{8'h0f, {4'h9, c[3:0]}, {c[0], c[0], 6'h0}}, OPC_SET_BYTE, c[0] ? 8'h04 : 8'h05, 0);
        end
        rin; op('{8'he3, 8'h05}, OPC_JUMP_COUNT16_ZERO, count_is_zero ? 8'h09 + next_components : 8'h05, 0);
        rin; op('{8'h67, 8'he3, 8'h05}, OPC_JUMP_COUNT32_ZERO, count_is_zero ? 8'h09 + next_components : 8'h05, 0);
        rin; op('{8'he2, 8'hfe}, OPC_LOOP, 8'h0b + next_components, 0);
        rin; op('{8'h2e, 8'hf0, 8'hc3}, OPC_RETURN_NEAR, 8'h0a + next_components, 0);
        rin; op('{8'hc2, 8'h04, 8'h00}, OPC_RETURN_NEAR, 8'h0a + next_components, 0);
        for (int p = 0; p < 4; p++) begin
            rin; protected_mode = p[0]; privilege_change = p[1];
            op('{8'hcb}, OPC_RETURN_FAR, p == 3 ? 8'h44 : (p[0] ? 8'h20 : 8'h12) + next_components, 0);
        end
        for (int i = 0; i < 16; i++) begin
            if (i == 9 || i == 11) continue;
            rin; op('{8'h0f, {7'h0, ~i[3]}, {2'h0, i[2:0], 3'h0}}, gc[i], gy[i], gy[i] == 0 ? 5'h06 : 5'h00);
        end
        rin; op('{8'h63, 8'hc0}, OPC_ADJUST_REQUESTED_PRIVILEGE, 8'h14, 0);
        rin; op('{8'h0f, 8'h02, 8'hc0}, OPC_LOAD_ACCESS_RIGHTS, 8'h0f, 0);
        rin; op('{8'hd9, 8'hc0}, OPC_COPROC, 8'hff, 0);
        chk("coproc_bits", 8'h08, coproc_bits);
        compat_mode = 1; io_access = 1; io_permitted = 0;
        op('{8'hc3}, OPC_RETURN_NEAR, 8'hff, 5'h0d);
        compat_mode = 0; io_access = 0; target_out_of_limit = 1;
        op('{8'hc3}, OPC_RETURN_NEAR, 8'hff, 5'h0d);
        target_out_of_limit = 0;
        protected_mode = 0;
        rin; op('{8'h63, 8'hc0}, OPC_ADJUST_REQUESTED_PRIVILEGE, 8'hff, 5'h06);
        rin; op('{8'h0f, 8'h00, 8'he0}, OPC_VERIFY_READABLE, 8'hff, 5'h06);
        tally_and_finish;
    end
endmodule
bind branch_prefix_protection_decode decode_asserts #(.CYC_W(CYC_W)) chk_i (.*);
`default_nettype wire
